// ===== pkg/msbi_pkg.sv
// Constants and types shared by the bus master controller
package msbi_pkg;

  // --------------------------------------------------------------
  // Bus field layout
  // --------------------------------------------------------------
  localparam int ADDR_W      = 22;
  localparam int DATA_W      = 16;
  localparam int BAD_LO_BIT  = 16;
  localparam int BAD_HI_BIT  = 17;

  // --------------------------------------------------------------
  // Timing counts
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;
  localparam int SETUP_NS       = 150;
  localparam int SETUP_CYC      = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DESKEW_NS      = 100;
  localparam int DESKEW_CYC     = (DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REPLY_TMO_CYC  = 1000;
  localparam int CNT_W          = 10;

  // --------------------------------------------------------------
  // Transfer kinds and states
  // --------------------------------------------------------------
  typedef enum logic [1:0]
  {
    MSBI_OP_READ  = 2'h0,
    MSBI_OP_WRITE = 2'h1,
    MSBI_OP_RMW   = 2'h2
  } msbi_op_type;

  typedef enum logic [3:0]
  {
    MSBI_IDLE    = 4'h0,
    MSBI_ADDR    = 4'h1,
    MSBI_SYNC    = 4'h3,
    MSBI_DIN     = 4'h2,
    MSBI_DIN_END = 4'h6,
    MSBI_DATA    = 4'h7,
    MSBI_DOUT    = 4'h5,
    MSBI_DOUT_END= 4'h4,
    MSBI_TERM    = 4'hC
  } msbi_state_type;

endpackage

// ===== rtl/msbi_master.sv
// Bus master controller driving a memory over the multiplexed bus
`timescale 1ns/1ps

// Notes on behaviour
// - Write_byte_select in address phase picks write
// - Io_page_select only during address phase
// - Transfer_sync marks address, held whole transfer
// - Output_strobe only with valid deskewed data
// - Slave_reply starts master termination
// - Write data on lines 15-00
module msbi_master
#(
  parameter int SETUP     = msbi_pkg::SETUP_CYC,
  parameter int DESKEW    = msbi_pkg::DESKEW_CYC,
  parameter int REPLY_TMO = msbi_pkg::REPLY_TMO_CYC
)
(
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rstn,
  // User command
  input  wire logic                        cmd_valid,
  output logic                             cmd_ready,
  input  wire msbi_pkg::msbi_op_type       cmd_op,
  input  wire logic                        cmd_byte,
  input  wire logic                        cmd_io,
  input  wire logic [msbi_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [msbi_pkg::DATA_W-1:0] cmd_wdata,
  // User answer
  output logic                             rsp_valid,
  output logic [msbi_pkg::DATA_W-1:0]      rsp_rdata,
  output logic                             rsp_bad,
  output logic                             rsp_timeout,
  // Multiplexed lines, active high inside the design
  input  wire logic [msbi_pkg::ADDR_W-1:0] dal_in,
  output logic      [msbi_pkg::ADDR_W-1:0] dal_out,
  output logic                             dal_oe,
  // Control pins
  output logic                             transfer_sync,
  output logic                             input_strobe,
  output logic                             output_strobe,
  output logic                             write_byte_select,
  output logic                             io_page_select,
  input  wire logic                        slave_reply
);
  import msbi_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic                rply_s;
  logic [ADDR_W-1:0]   dal_s;

  msbi_sync3 #(.W(1)) u_rply
  (
    .clk  (clk),
    .rstn (rstn),
    .din  (slave_reply),
    .dout (rply_s)
  );

  msbi_sync3 #(.W(ADDR_W)) u_dal
  (
    .clk  (clk),
    .rstn (rstn),
    .din  (dal_in),
    .dout (dal_s)
  );

  // ----------------------------------------------------------------
  // Command capture
  // ----------------------------------------------------------------
  msbi_state_type      state_r;
  msbi_state_type      state_nxt;
  msbi_op_type         op_r;
  logic                byte_r;
  logic                io_r;
  logic [ADDR_W-1:0]   addr_r;
  logic [DATA_W-1:0]   wdata_r;
  logic [CNT_W-1:0]    cnt_r;
  logic                tmo_r;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      op_r    <= MSBI_OP_READ;
      byte_r  <= 1'b0;
      io_r    <= 1'b0;
      addr_r  <= '0;
      wdata_r <= '0;
    end
    else if (state_r == MSBI_IDLE && cmd_valid)
    begin
      op_r    <= cmd_op;
      byte_r  <= cmd_byte;
      io_r    <= cmd_io;
      addr_r  <= cmd_addr;
      wdata_r <= cmd_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Timeout guards a missing slave; the bus would otherwise hang
  function automatic logic cnt_done(input logic [CNT_W-1:0] c, input int lim);
    cnt_done = (c >= CNT_W'(lim - 1));
  endfunction

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      MSBI_IDLE:
        if (cmd_valid)
          state_nxt = MSBI_ADDR;
      MSBI_ADDR:
        if (cnt_done(cnt_r, SETUP))
          state_nxt = MSBI_SYNC;
      MSBI_SYNC:
        if (cnt_done(cnt_r, SETUP))
          state_nxt = (op_r == MSBI_OP_WRITE) ? MSBI_DATA : MSBI_DIN;
      MSBI_DIN:
        if (rply_s || cnt_done(cnt_r, REPLY_TMO))
          state_nxt = MSBI_DIN_END;
      MSBI_DIN_END:
        if (!rply_s)
          state_nxt = (op_r == MSBI_OP_RMW) ? MSBI_DATA : MSBI_TERM;
      MSBI_DATA:
        if (cnt_done(cnt_r, DESKEW))
          state_nxt = MSBI_DOUT;
      MSBI_DOUT:
        if (rply_s || cnt_done(cnt_r, REPLY_TMO))
          state_nxt = MSBI_DOUT_END;
      MSBI_DOUT_END:
        if (!rply_s)
          state_nxt = MSBI_TERM;
      MSBI_TERM:
        state_nxt = MSBI_IDLE;
      default:
        state_nxt = MSBI_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state_r <= MSBI_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt_r <= '0;
    else if (state_nxt != state_r)
      cnt_r <= '0;
    else if (cnt_r != '1)
      cnt_r <= cnt_r + 1'b1;
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      transfer_sync     <= 1'b0;
      input_strobe      <= 1'b0;
      output_strobe     <= 1'b0;
      write_byte_select <= 1'b0;
      io_page_select    <= 1'b0;
      dal_out           <= '0;
      dal_oe            <= 1'b0;
    end
    else
    begin
      // Sync held from the end of address setup through reply release
      transfer_sync  <= state_nxt inside {MSBI_SYNC, MSBI_DIN, MSBI_DIN_END,
                                          MSBI_DATA, MSBI_DOUT, MSBI_DOUT_END};
      io_page_select <= io_r && (state_nxt inside {MSBI_ADDR, MSBI_SYNC});
      input_strobe   <= (state_nxt == MSBI_DIN);
      output_strobe  <= (state_nxt == MSBI_DOUT);
      case (state_nxt)
        MSBI_ADDR, MSBI_SYNC:
        begin
          dal_out           <= addr_r;
          dal_oe            <= 1'b1;
          write_byte_select <= (op_r == MSBI_OP_WRITE);
        end
        MSBI_DATA, MSBI_DOUT:
        begin
          dal_out           <= {{(ADDR_W-DATA_W){1'b0}}, wdata_r};
          dal_oe            <= 1'b1;
          write_byte_select <= byte_r;
        end
        default:
        begin
          dal_out           <= '0;
          dal_oe            <= 1'b0; // Lines freed for slave read data
          write_byte_select <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // User answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tmo_r <= 1'b0;
    else if (state_r == MSBI_IDLE)
      tmo_r <= 1'b0;
    else if ((state_r == MSBI_DIN || state_r == MSBI_DOUT) && !rply_s
             && cnt_done(cnt_r, REPLY_TMO))
      tmo_r <= 1'b1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rsp_rdata <= '0;
      rsp_bad   <= 1'b0;
    end
    else if (state_r == MSBI_DIN && rply_s)
    begin
      rsp_rdata <= dal_s[DATA_W-1:0];
      rsp_bad   <= dal_s[BAD_LO_BIT] | dal_s[BAD_HI_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rsp_valid   <= 1'b0;
      rsp_timeout <= 1'b0;
      cmd_ready   <= 1'b0;
    end
    else
    begin
      rsp_valid   <= (state_nxt == MSBI_TERM);
      rsp_timeout <= (state_nxt == MSBI_TERM) && tmo_r;
      cmd_ready   <= (state_nxt == MSBI_IDLE);
    end
  end

endmodule // msbi_master

// ===== rtl/msbi_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module msbi_sync3
#(
  parameter int W = 1
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Change accepted only when stages two and three agree
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          dout[g] <= 1'b0;
        else if (s2_r[g] == s3_r[g])
          dout[g] <= s3_r[g];
      end
    end
  endgenerate

endmodule // msbi_sync3

// ===== testbench/msbi_master_properties.sv
// Port checks on the bus master controller
`timescale 1ns/1ps
module msbi_master_properties
(
  // Clock, reset and command
  input wire logic                        clk,
  input wire logic                        rstn,
  input wire logic                        cmd_valid,
  input wire logic                        cmd_ready,
  input wire msbi_pkg::msbi_op_type       cmd_op,
  input wire logic [msbi_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [msbi_pkg::DATA_W-1:0] cmd_wdata,
  // Bus side
  input wire logic [msbi_pkg::ADDR_W-1:0] dal_out,
  input wire logic                        dal_oe,
  input wire logic                        transfer_sync,
  input wire logic                        input_strobe,
  input wire logic                        output_strobe,
  input wire logic                        write_byte_select,
  input wire logic                        io_page_select,
  input wire logic                        slave_reply
);
  import msbi_pkg::*;
  msbi_op_type       op_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wd_r;
  // ----------------------------------------
  // Command capture
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (cmd_valid && cmd_ready)
    begin
      op_r   <= cmd_op;
      addr_r <= cmd_addr;
      wd_r   <= cmd_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_dir;
    $rose(transfer_sync) |-> write_byte_select == (op_r == MSBI_OP_WRITE);
  endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");
  property p_io_off;
    io_page_select |-> !input_strobe && !output_strobe;
  endproperty
  a_io_off: assert property (p_io_off) else $error("io select in data");
  property p_addr;
    $rose(transfer_sync) |-> dal_oe && dal_out == addr_r;
  endproperty
  a_addr: assert property (p_addr) else $error("address wrong");
  property p_sync;
    (input_strobe || output_strobe) |-> transfer_sync;
  endproperty
  a_sync: assert property (p_sync) else $error("strobe without sync");
  property p_deskew;
    $rose(output_strobe) |-> $past(dal_oe) && $stable(dal_out) && dal_out[15:0] == wd_r;
  endproperty
  a_deskew: assert property (p_deskew) else $error("write data unsettled");
  property p_term;
    (input_strobe || output_strobe) && slave_reply |-> ##[1:8] !(input_strobe || output_strobe);
  endproperty
  a_term: assert property (p_term) else $error("no termination");
endmodule // msbi_master_properties

// ===== testbench/msbi_mem_model.sv
// Behavioural memory answering the bus master
`timescale 1ns/1ps
module msbi_mem_model
#(
  parameter logic [7:0]  CSR_LOC  = 8'hA5,
  parameter logic [21:0] BAD_ADDR = 22'h000100
)
(
  // Clock and knobs
  input  wire logic        clk,
  input  var  int          dly,
  input  wire logic        refresh,
  input  wire logic        mute,
  // Bus, active high logical
  input  wire logic [21:0] bus,
  input  wire logic        sync,
  input  wire logic        din,
  input  wire logic        dout,
  input  wire logic        wbs,
  input  wire logic        io,
  output logic             reply = 1'b0,
  output logic             drv = 1'b0,
  output logic [21:0]      rdv = 22'h0
);
  bit   [15:0] mem [int];
  logic [15:0] csr = 16'h0;
  logic [21:0] a;
  logic        io_l;
  logic        hit;
  assign hit = io_l && (a[12:5] == CSR_LOC);
  always @(posedge sync)
  begin
    a    = bus;
    io_l = io;
  end
  // Refresh wins, so a request may wait
  task automatic wait_turn;
    // Falling edge keeps reply and data clear of the sampling edge
    repeat (dly) @(negedge clk);
    while (refresh) @(negedge clk);
  endtask
  always @(posedge din)
  begin
    wait_turn();
    rdv   = {4'h0, {2{a == BAD_ADDR}}, hit ? csr : mem[a[21:1]]};
    drv   = !mute;
    reply = !mute;
  end
  always @(negedge din)
  begin
    reply = 1'b0;
    drv   = 1'b0;
  end
  always @(posedge dout)
  begin
    wait_turn();
    if (hit)
      csr = bus[15:0];
    else if (!wbs)
      mem[a[21:1]] = bus[15:0];
    else if (a[0])
      mem[a[21:1]][15:8] = bus[15:8];
    else
      mem[a[21:1]][7:0] = bus[7:0];
    reply = !mute;
  end
  always @(negedge dout)
    reply = 1'b0;
endmodule // msbi_mem_model

// ===== testbench/tb_top.sv
// Self-checking bench for the bus master controller
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  import msbi_pkg::*;
  logic        clk, rstn, cmd_valid, cmd_ready, cmd_byte, cmd_io, rsp_valid, rsp_bad;
  logic        rsp_timeout, dal_oe, sync, din, dout, wbs, io, reply, drv, refresh, mute, tmo;
  logic [21:0] cmd_addr, dal_in, dal_out, rdv;
  logic [15:0] cmd_wdata, rsp_rdata;
  msbi_op_type cmd_op;
  int          dly, n, cyc, miscompares, comparisons;
  // Released bus rests at its terminated level, logical 0
  assign dal_in = dal_oe ? dal_out : (drv ? rdv : 22'h0);
  // Timeout above the refresh hold-off, so only a silent memory trips it
  msbi_master #(.REPLY_TMO(60)) msbi_master_i (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_byte(cmd_byte), .cmd_io(cmd_io),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_bad(rsp_bad), .rsp_timeout(rsp_timeout), .dal_in(dal_in), .dal_out(dal_out),
    .dal_oe(dal_oe), .transfer_sync(sync), .input_strobe(din), .output_strobe(dout),
    .write_byte_select(wbs), .io_page_select(io), .slave_reply(reply));
  msbi_mem_model msbi_mem_model_i (.clk(clk), .dly(dly), .refresh(refresh), .mute(mute),
    .bus(dal_in), .sync(sync), .din(din), .dout(dout), .wbs(wbs), .io(io), .reply(reply),
    .drv(drv), .rdv(rdv));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic close_out;
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      close_out();
    end
  end
  task automatic xfer(input msbi_op_type op, input logic byt, iop, input logic [21:0] ad,
                      input logic [15:0] wd);
    while (cmd_ready !== 1'b1) @(negedge clk);
    cmd_op    = op;
    cmd_byte  = byt;
    cmd_io    = iop;
    cmd_addr  = ad;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    tmo = rsp_timeout;
    `CHK(rsp_valid, 1'b1)
  endtask
  task automatic t_word;
    xfer(MSBI_OP_WRITE, 1'b0, 1'b0, 22'h200010, 16'hA55A);
    xfer(MSBI_OP_READ, 1'b0, 1'b0, 22'h200010, 16'h0);
    `CHK(rsp_rdata, 16'hA55A)
    `CHK(rsp_bad, 1'b0)
  endtask
  task automatic t_byte_rmw;
    xfer(MSBI_OP_WRITE, 1'b0, 1'b0, 22'h000022, 16'h1234);
    xfer(MSBI_OP_WRITE, 1'b1, 1'b0, 22'h000023, 16'hAB00);
    xfer(MSBI_OP_WRITE, 1'b1, 1'b0, 22'h000022, 16'hEECD);
    xfer(MSBI_OP_RMW, 1'b0, 1'b0, 22'h000022, 16'h5678);
    `CHK(rsp_rdata, 16'hABCD)
    xfer(MSBI_OP_READ, 1'b0, 1'b0, 22'h000022, 16'h0);
    `CHK(rsp_rdata, 16'h5678)
    xfer(MSBI_OP_RMW, 1'b1, 1'b0, 22'h000023, 16'h9900);
    `CHK(rsp_rdata, 16'h5678)
    xfer(MSBI_OP_READ, 1'b0, 1'b0, 22'h000022, 16'h0);
    `CHK(rsp_rdata, 16'h9978)
  endtask
  task automatic t_io_bad;
    xfer(MSBI_OP_WRITE, 1'b0, 1'b1, 22'h0014A0, 16'h0F0F);
    xfer(MSBI_OP_READ, 1'b0, 1'b0, 22'h0014A0, 16'h0);
    `CHK(rsp_rdata, 16'h0000)
    xfer(MSBI_OP_READ, 1'b0, 1'b1, 22'h0014A0, 16'h0);
    `CHK(rsp_rdata, 16'h0F0F)
    xfer(MSBI_OP_READ, 1'b0, 1'b0, 22'h000100, 16'h0);
    `CHK(rsp_bad, 1'b1)
  endtask
  // Slow answer held off by refresh, then a silent memory
  task automatic t_slow_mute;
    dly     = 5;
    refresh = 1'b1;
    fork
      xfer(MSBI_OP_WRITE, 1'b0, 1'b0, 22'h000040, 16'h3C3C);
      begin
        repeat (30) @(negedge clk);
        refresh = 1'b0;
      end
    join
    `CHK(n > 30, 1'b1)
    `CHK(tmo, 1'b0)
    mute = 1'b1;
    xfer(MSBI_OP_READ, 1'b0, 1'b0, 22'h000040, 16'h0);
    `CHK(tmo, 1'b1)
    mute = 1'b0;
    dly  = 0;
    xfer(MSBI_OP_READ, 1'b0, 1'b0, 22'h000040, 16'h0);
    `CHK(rsp_rdata, 16'h3C3C)
  endtask
  initial
  begin
    {rstn, cmd_valid, cmd_byte, cmd_io, refresh, mute} = 6'h00;
    cmd_op    = MSBI_OP_READ;
    cmd_addr  = 22'h0;
    cmd_wdata = 16'h0;
    dly       = 0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    t_word();
    t_byte_rmw();
    t_io_bad();
    t_slow_mute();
    close_out();
  end
endmodule // tb_top
bind msbi_master msbi_master_properties msbi_master_properties_i (.clk(clk), .rstn(rstn),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
  .cmd_wdata(cmd_wdata), .dal_out(dal_out), .dal_oe(dal_oe), .transfer_sync(transfer_sync),
  .input_strobe(input_strobe), .output_strobe(output_strobe),
  .write_byte_select(write_byte_select), .io_page_select(io_page_select),
  .slave_reply(slave_reply));
